// ### hw/mps_sequencer.sv
// Purpose: Instruction sequencer: phases, fetch pipeline, PC, return stack, ALU.
// Assumes: Program memory answers combinationally to pmAddr within the four phases of an instruction cycle.
// Notes:   Registers reached over classic Wishbone; interrupt request on same clock.
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int PC_W        = PC_W_DEF,
    parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               wbCyc,
    input  wire logic               wbStb,
    input  wire logic               wbWe,
    input  wire logic [7:0]         wbAdr,
    input  wire logic [3:0]         wbSel,
    input  wire logic [31:0]        wbDatW,
    output logic      [31:0]        wbDatR,
    output logic                    wbAck,
    output logic      [PC_W-1:0]    pmAddr,
    input  wire logic [INSTR_W-1:0] pmData,
    input  wire logic               intReq,
    output logic                    intAck,
    output mps_phase_t              instructionPhases
);
    localparam int SP_W = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

    mps_phase_t         phase;
    logic [PC_W-1:0]    pc;
    logic [INSTR_W-1:0] instr;
    logic               instrValid;
    logic [7:0]         acc;
    logic [3:0]         status;
    logic               intEn;
    logic               intPending;
    logic               pclPend;
    logic [7:0]         pclVal;
    logic [PC_W-1:0]    stackMem [STACK_DEPTH];
    logic [SP_W-1:0]    sp;

    logic [1:0]         cls;
    logic [3:0]         sub;
    logic [7:0]         imm;
    logic               commit;
    logic               isAlu;
    logic               isMisc;
    logic               isJmp;
    logic               isCall;
    logic               isRet;
    logic               isMovPcl;
    logic               skipTaken;
    logic               xfer;
    logic               stackFull;
    logic               takeInt;
    logic               takePcl;
    logic               push;
    logic               pop;
    logic               dummy;
    logic [PC_W-1:0]    next_pc;
    logic [7:0]         aluRes;
    logic [3:0]         aluFlags;
    logic               aluWrite;
    logic [7:0]         addB;
    logic               addCin;
    logic [8:0]         sum9;
    logic [4:0]         half5;
    logic [8:0]         daa9;
    logic               busReq;

    // Phase counter: T4 is the commit edge of each instruction cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= PH_T1;
        end else begin
            case (phase)
                PH_T1:   phase <= PH_T2;
                PH_T2:   phase <= PH_T3;
                PH_T3:   phase <= PH_T4;
                PH_T4:   phase <= PH_T1;
                default: phase <= PH_T1;
            endcase
        end
    end

    assign instructionPhases = phase;
    assign commit            = (phase == PH_T4);

    // Decode of the instruction in execution
    assign cls       = instr[CLS_MSB:CLS_LSB];
    assign sub       = instr[SUB_MSB:SUB_LSB];
    assign imm       = instr[7:0];
    assign isAlu     = instrValid && (cls == CLS_ALU);
    assign isMisc    = instrValid && (cls == CLS_MISC);
    assign isJmp     = instrValid && (cls == CLS_JMP);
    assign isCall    = isJmp && instr[CALL_BIT];
    assign isRet     = isMisc && (sub == MSC_RET || sub == MSC_INTERRUPT_RETURN);
    assign isMovPcl  = isMisc && (sub == MSC_PCL);
    assign stackFull = (sp == SP_FULL);

    always_comb begin
        skipTaken = 1'b0;
        if (isMisc) begin
            case (mps_misc_op_t'(sub))
                MSC_SZ:  skipTaken = (acc == 8'h00);
                MSC_SNZ: skipTaken = (acc != 8'h00);
                MSC_SIZ: skipTaken = (acc == 8'hFF);
                MSC_SDZ: skipTaken = (acc == 8'h01);
                default: skipTaken = 1'b0;
            endcase
        end
    end

    assign xfer    = isJmp || isRet || isMovPcl || skipTaken;
    assign takePcl = pclPend && !xfer;
    assign takeInt = intPending && intEn && !stackFull && !xfer && !pclPend;
    assign push    = commit && (isCall || takeInt);
    assign pop     = commit && isRet;
    assign dummy   = xfer || takePcl || takeInt;

    always_comb begin
        if (isJmp) begin
            next_pc = instr[PC_W-1:0];
        end else if (isRet) begin
            next_pc = stackMem[0];
        end else if (isMovPcl) begin
            next_pc = {pc[PC_W-1:8], acc};
        end else if (takePcl) begin
            next_pc = {pc[PC_W-1:8], pclVal};
        end else if (takeInt) begin
            next_pc = INT_VECTOR[PC_W-1:0];
        end else begin
            next_pc = pc + 1'b1;
        end
    end

    // Fetch pipeline: next word is latched while the current one retires
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc         <= RESET_VECTOR[PC_W-1:0];
            instr      <= '0;
            instrValid <= 1'b0;
        end else if (commit) begin
            pc         <= next_pc;
            instr      <= pmData;
            instrValid <= !dummy;
        end
    end

    assign pmAddr = pc;

    // ALU: shared adder for add and subtract families
    always_comb begin
        addB   = imm;
        addCin = 1'b0;
        case (mps_alu_op_t'(sub))
            ALU_ADC: addCin = status[ST_C];
            ALU_SUB: begin
                addB   = ~imm;
                addCin = 1'b1;
            end
            ALU_SBC: begin
                addB   = ~imm;
                addCin = status[ST_C];
            end
            default: addCin = 1'b0;
        endcase
        sum9  = {1'b0, acc} + {1'b0, addB} + {8'h00, addCin};
        half5 = {1'b0, acc[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};
        daa9  = {1'b0, acc};
        if (acc[3:0] > 4'h9 || status[ST_AC]) begin
            daa9 = daa9 + 9'h006;
        end
        if (daa9[7:4] > 4'h9 || status[ST_C] || daa9[8]) begin
            daa9 = daa9 + 9'h060;
        end
    end

    always_comb begin
        aluRes   = acc;
        aluFlags = status;
        aluWrite = 1'b0;
        if (isAlu) begin
            aluWrite = 1'b1;
            case (mps_alu_op_t'(sub))
                ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
                    aluRes          = sum9[7:0];
                    aluFlags[ST_C]  = sum9[8];
                    aluFlags[ST_AC] = half5[4];
                    aluFlags[ST_OV] = (acc[7] == addB[7]) && (sum9[7] != acc[7]);
                end
                ALU_DAA: begin
                    aluRes         = daa9[7:0];
                    aluFlags[ST_C] = daa9[8] | status[ST_C];
                end
                ALU_AND: aluRes = acc & imm;
                ALU_OR:  aluRes = acc | imm;
                ALU_XOR: aluRes = acc ^ imm;
                ALU_CPL: aluRes = ~acc;
                ALU_RR:  aluRes = {acc[0], acc[7:1]};
                ALU_RL:  aluRes = {acc[6:0], acc[7]};
                ALU_RRC: begin
                    aluRes         = {status[ST_C], acc[7:1]};
                    aluFlags[ST_C] = acc[0];
                end
                ALU_RLC: begin
                    aluRes         = {acc[6:0], status[ST_C]};
                    aluFlags[ST_C] = acc[7];
                end
                ALU_INC: aluRes = acc + 8'h01;
                ALU_DEC: aluRes = acc - 8'h01;
                ALU_MOV: aluRes = imm;
                default: aluRes = acc;
            endcase
            if (sub != ALU_RR && sub != ALU_RL && sub != ALU_RRC && sub != ALU_RLC) begin
                aluFlags[ST_Z] = (aluRes == 8'h00);
            end
        end else if (isMisc && sub == MSC_SIZ) begin
            aluWrite = 1'b1;
            aluRes   = acc + 8'h01;
        end else if (isMisc && sub == MSC_SDZ) begin
            aluWrite = 1'b1;
            aluRes   = acc - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc    <= ACC_RESET;
            status <= STATUS_RESET;
        end else if (commit && aluWrite) begin
            acc    <= aluRes;
            status <= aluFlags;
        end
    end

    // Return stack: shift register, entry 0 is the top; hidden from the bus
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                stackMem[i] <= '0;
            end else if (push) begin
                if (i == 0) begin
                    stackMem[i] <= pc;
                end else begin
                    stackMem[i] <= stackMem[(i == 0) ? 0 : i - 1];
                end
            end else if (pop) begin
                if (i == STACK_DEPTH - 1) begin
                    stackMem[i] <= '0;
                end else begin
                    stackMem[i] <= stackMem[(i == STACK_DEPTH - 1) ? i : i + 1];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp <= '0;
        end else if (push && !stackFull) begin
            sp <= sp + 1'b1;
        end else if (pop && sp != '0) begin
            sp <= sp - 1'b1;
        end
    end

    // Interrupt request is held until acknowledged; a new request wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intPending <= 1'b0;
            intEn      <= 1'b0;
            intAck     <= 1'b0;
        end else begin
            intPending <= intReq || (intPending && !(commit && takeInt));
            intAck     <= commit && takeInt;
            if (commit && takeInt) begin
                intEn <= 1'b0;
            end else if (commit && isMisc && (sub == MSC_INTERRUPT_RETURN || sub == MSC_EI)) begin
                intEn <= 1'b1;
            end else if (commit && isMisc && sub == MSC_DI) begin
                intEn <= 1'b0;
            end
        end
    end

    // Wishbone slave: single-cycle ack, unmapped reads return zero
    assign busReq = wbCyc && wbStb && !wbAck;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wbAck  <= 1'b0;
            wbDatR <= '0;
        end else begin
            wbAck <= busReq;
            if (busReq && !wbWe) begin
                case (wbAdr)
                    ADR_PCL: wbDatR <= {24'h000000, pc[7:0]};
                    ADR_ACC: wbDatR <= {20'h00000, status, acc};
                    default: wbDatR <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pclPend <= 1'b0;
            pclVal  <= 8'h00;
        end else if (busReq && wbWe && wbAdr == ADR_PCL && wbSel[0]) begin
            pclPend <= 1'b1;
            pclVal  <= wbDatW[7:0];
        end else if (commit && takePcl) begin
            pclPend <= 1'b0;
        end
    end
endmodule

// ### hw/mps_pkg.sv
// Purpose: Shared constants and types for the program sequencer.
// Assumes: 14-bit instruction words; encodings below are local to this core.
// Notes:   Bus offsets are byte addresses on a 32-bit classic Wishbone port.
package mps_pkg;
    localparam int          PC_W_DEF        = 10;
    localparam int          STACK_DEPTH_DEF = 4;
    localparam int          INSTR_W         = 14;
    localparam int          CLS_MSB         = 13;
    localparam int          CLS_LSB         = 12;
    localparam int          SUB_MSB         = 11;
    localparam int          SUB_LSB         = 8;
    localparam int          CALL_BIT        = 11;
    localparam logic [1:0]  CLS_ALU         = 2'h0;
    localparam logic [1:0]  CLS_JMP         = 2'h1;
    localparam logic [1:0]  CLS_MISC        = 2'h2;
    localparam logic [10:0] RESET_VECTOR    = 11'h000;
    localparam logic [10:0] INT_VECTOR      = 11'h004;
    localparam logic [7:0]  ADR_PCL         = 8'h00;
    localparam logic [7:0]  ADR_ACC         = 8'h04;
    localparam logic [7:0]  ACC_RESET       = 8'h00;
    localparam logic [3:0]  STATUS_RESET    = 4'h0;
    localparam int          ST_C            = 0;
    localparam int          ST_AC           = 1;
    localparam int          ST_Z            = 2;
    localparam int          ST_OV           = 3;

    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } mps_phase_t;

    typedef enum logic [3:0] {
        ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
        ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR  = 4'h6, ALU_XOR = 4'h7,
        ALU_CPL = 4'h8, ALU_RR  = 4'h9, ALU_RRC = 4'hA, ALU_RL  = 4'hB,
        ALU_RLC = 4'hC, ALU_INC = 4'hD, ALU_DEC = 4'hE, ALU_MOV = 4'hF
    } mps_alu_op_t;

    typedef enum logic [3:0] {
        MSC_RET  = 4'h0, MSC_INTERRUPT_RETURN = 4'h1, MSC_SZ  = 4'h2, MSC_SNZ = 4'h3,
        MSC_SIZ  = 4'h4, MSC_SDZ  = 4'h5, MSC_PCL = 4'h6, MSC_EI  = 4'h7,
        MSC_DI   = 4'h8
    } mps_misc_op_t;
endpackage

// ### bench/mps_sequencer_monitor.sv
// Purpose: Port-level checks on the program sequencer.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Attached by the bind after the module.
`timescale 1ns/1ps
module mps_sequencer_monitor
    import mps_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    input wire logic            clk,
    input wire logic            reset_n,
    input wire logic            wbCyc,
    input wire logic            wbStb,
    input wire logic            wbWe,
    input wire logic [7:0]      wbAdr,
    input wire logic [31:0]     wbDatR,
    input wire logic            wbAck,
    input wire logic [PC_W-1:0] pmAddr,
    input wire logic            intAck,
    input wire mps_phase_t      instructionPhases
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence phaseRest_s;
        instructionPhases == PH_T2 ##1 instructionPhases == PH_T3
            ##1 instructionPhases == PH_T4 ##1 instructionPhases == PH_T1;
    endsequence
    sequence ackPulse_s;
        wbAck ##1 !wbAck;
    endsequence

    phase_cycle_a: assert property (instructionPhases == PH_T1 |=> phaseRest_s)
        else $error("phase order broken");
    fetch_hold_a: assert property (instructionPhases != PH_T4 |=> $stable(pmAddr))
        else $error("fetch address moved outside the last phase");
    bus_ack_a: assert property (wbCyc && wbStb && !wbAck |=> ackPulse_s)
        else $error("bus answer not a one-cycle pulse");
    pcl_read_a: assert property (wbAck && !wbWe && wbAdr == ADR_PCL |-> wbDatR[31:8] == 24'h0)
        else $error("program counter read shows upper bits");
    unmapped_zero_a: assert property (wbAck && !wbWe && wbAdr != ADR_PCL && wbAdr != ADR_ACC
        |-> wbDatR == 32'h0)
        else $error("unmapped read not zero");
    int_vector_a: assert property (intAck |-> pmAddr == INT_VECTOR[PC_W-1:0])
        else $error("interrupt entry not at vector");
    int_pulse_a: assert property (intAck |=> !intAck)
        else $error("interrupt acknowledge too long");
    reset_vector_a: assert property ($rose(reset_n)
        |-> pmAddr == RESET_VECTOR[PC_W-1:0] && instructionPhases == PH_T1)
        else $error("reset state wrong");
    first_step_a: assert property ($rose(reset_n) |-> ##4 pmAddr == PC_W'(1))
        else $error("first fetch did not advance");
endmodule

bind mps_sequencer mps_sequencer_monitor #(.PC_W(PC_W)) mon (
    .clk(clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck), .pmAddr(pmAddr),
    .intAck(intAck), .instructionPhases(instructionPhases));

// ### bench/mps_prog_mem.sv
// Purpose: Program memory holding a small test program.
// Assumes: Word follows the fetch address with no delay.
// Notes:   Unwritten words decode as no-ops.
`timescale 1ns/1ps
module mps_prog_mem
    import mps_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    input  wire logic [PC_W-1:0]    pmAddr,
    output logic      [INSTR_W-1:0] pmData
);
    logic [INSTR_W-1:0] rom [0:(1<<PC_W)-1];

    initial begin
        for (int i = 0; i < (1 << PC_W); i++) begin
            rom[i] = 14'h3000;
        end
        rom[10'h000] = 14'h1010;
        rom[10'h004] = 14'h2100;
        rom[10'h010] = 14'h0F5A;
        rom[10'h011] = 14'h00A6;
        rom[10'h012] = 14'h2700;
        // Four nested calls fill the stack, then spin at 023
        rom[10'h013] = 14'h1820;
        rom[10'h020] = 14'h1821;
        rom[10'h021] = 14'h1822;
        rom[10'h022] = 14'h1823;
        rom[10'h023] = 14'h1023;
        rom[10'h024] = 14'h2000;
        // Reached by a low byte write: sub, taken skip, two calls, the second past a full stack
        rom[10'h030] = 14'h0F10;
        rom[10'h031] = 14'h0210;
        rom[10'h032] = 14'h2200;
        rom[10'h033] = 14'h0F55;
        rom[10'h034] = 14'h073C;
        rom[10'h035] = 14'h1840;
        rom[10'h036] = 14'h1036;
        rom[10'h040] = 14'h1841;
        rom[10'h041] = 14'h2000;
    end

    assign pmData = rom[pmAddr];
endmodule

// ### bench/mps_sequencer_tb.sv
// Purpose: Self-checking bench for the program sequencer.
// Assumes: Program image in mps_prog_mem.
// Notes:   Bus tasks wait on ack; interrupts driven from here.
`timescale 1ns/1ps
module mps_sequencer_tb
    import mps_pkg::*;
;
    localparam int PC_W = 10;
    logic               clk;
    logic               reset_n;
    logic               wbCyc;
    logic               wbStb;
    logic               wbWe;
    logic [7:0]         wbAdr;
    logic [3:0]         wbSel;
    logic [31:0]        wbDatW;
    logic [31:0]        wbDatR;
    logic               wbAck;
    logic [PC_W-1:0]    pmAddr;
    logic [INSTR_W-1:0] pmData;
    logic               intReq;
    logic               intAck;
    mps_phase_t         instructionPhases;
    int                 errors;
    int                 total_checks;
    logic [31:0]        rd;
    logic               got;

    mps_sequencer #(.PC_W(PC_W), .STACK_DEPTH(4)) DUT (
        .clk(clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
        .pmAddr(pmAddr), .pmData(pmData), .intReq(intReq), .intAck(intAck),
        .instructionPhases(instructionPhases));
    mps_prog_mem #(.PC_W(PC_W)) pmem (.pmAddr(pmAddr), .pmData(pmData));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                            input logic [31:0] dat, output logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1);
        check({31'h0, wbAck}, 32'h1);
        check(32'(n), 32'h2);
        data = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    // Optionally raise a one-cycle request, then watch for acknowledge
    task automatic watch_int(input logic raise, input int lim, output logic seen);
        @(posedge clk);
        intReq <= raise;
        @(posedge clk);
        intReq <= 1'b0;
        seen = 1'b0;
        repeat (lim) begin
            @(posedge clk);
            if (intAck === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        errors = 0;
        total_checks = 0;
        reset_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h0;
        intReq = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (200) @(posedge clk);
        wb_cycle(1'b0, ADR_ACC, 4'hF, 32'h0, rd);
        check(rd, 32'h00000700);
        wb_cycle(1'b1, ADR_ACC, 4'hF, 32'h000000FF, rd);
        wb_cycle(1'b0, ADR_ACC, 4'hF, 32'h0, rd);
        check(rd, 32'h00000700);
        wb_cycle(1'b0, 8'h08, 4'hF, 32'h0, rd);
        check(rd, 32'h0);
        wb_cycle(1'b0, ADR_PCL, 4'hF, 32'h0, rd);
        check({31'h0, rd[7:0] == 8'h23 || rd[7:0] == 8'h24}, 32'h1);
        $display("alu and register map test done");
        watch_int(1'b1, 200, got);
        check({31'h0, got}, 32'h0);
        wb_cycle(1'b1, ADR_PCL, 4'h0, 32'h00000024, rd);
        watch_int(1'b0, 100, got);
        check({31'h0, got}, 32'h0);
        wb_cycle(1'b1, ADR_PCL, 4'h1, 32'h00000024, rd);
        watch_int(1'b0, 100, got);
        check({31'h0, got}, 32'h1);
        $display("full stack interrupt test done");
        watch_int(1'b1, 60, got);
        check({31'h0, got}, 32'h1);
        wb_cycle(1'b0, ADR_PCL, 4'hF, 32'h0, rd);
        check({31'h0, rd[7:0] == 8'h23 || rd[7:0] == 8'h24}, 32'h1);
        $display("interrupt return test done");
        wb_cycle(1'b1, ADR_PCL, 4'h1, 32'h00000030, rd);
        repeat (120) @(posedge clk);
        wb_cycle(1'b0, ADR_ACC, 4'hF, 32'h0, rd);
        check(rd, 32'h0000033C);
        wb_cycle(1'b0, ADR_PCL, 4'hF, 32'h0, rd);
        check({31'h0, rd[7:0] == 8'h36 || rd[7:0] == 8'h37}, 32'h1);
        $display("skip and stack overflow test done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(pmAddr), 32'(RESET_VECTOR));
        check(32'(instructionPhases), 32'(PH_T1));
        reset_n <= 1'b1;
        repeat (200) @(posedge clk);
        wb_cycle(1'b0, ADR_ACC, 4'hF, 32'h0, rd);
        check(rd, 32'h00000700);
        $display("mid-run reset test done");
        print_verdict();
    end
endmodule
